// *** pkg/ipr_pkg.sv ***
/*
 * constants for the interrupt priority register bank six to ten:
 * register offsets, field layout, reset values and bus answers.
 * assumes a 32-bit axi4-lite slave with one aligned word per register.
 */
package ipr_pkg;

   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int NUM_REGS = 5;
   localparam int FIELD_W = 3;
   localparam int NUM_SRCS = 20;

   // byte offsets of the priority control registers
   localparam logic [7:0] OFF_PRIO_CTRL_SIX = 8'h00;
   localparam logic [7:0] OFF_PRIO_CTRL_SEVEN = 8'h04;
   localparam logic [7:0] OFF_PRIO_CTRL_EIGHT = 8'h08;
   localparam logic [7:0] OFF_PRIO_CTRL_NINE = 8'h0C;
   localparam logic [7:0] OFF_PRIO_CTRL_TEN = 8'h10;

   // register index of each priority control register
   localparam logic [2:0] IDX_SIX = 3'h0;
   localparam logic [2:0] IDX_SEVEN = 3'h1;
   localparam logic [2:0] IDX_EIGHT = 3'h2;
   localparam logic [2:0] IDX_NINE = 3'h3;
   localparam logic [2:0] IDX_TEN = 3'h4;

   // lowest bit of each field inside a register
   localparam int FLD_HI_LSB = 12;
   localparam int FLD_MH_LSB = 8;
   localparam int FLD_ML_LSB = 4;
   localparam int FLD_LO_LSB = 0;

   // field codes
   localparam logic [2:0] PRIO_OFF = 3'h0;
   localparam logic [2:0] PRIO_MIN = 3'h1;
   localparam logic [2:0] PRIO_MAX = 3'h7;

   // reset value: every field at level four, unimplemented bits clear
   localparam logic [15:0] PRIO_RESET = 16'h4444;
   localparam logic [15:0] PRIO_IMPL_MASK = 16'h7777;

   // axi answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** design/ipr_prio_reg.sv ***
/*
 * one 16-bit priority control register holding four 3-bit fields.
 * assumes the caller decodes the address and gives a one-cycle write
 * enable with the two low byte strobes of the bus.
 */
`timescale 1ns/1ps

module ipr_prio_reg
   import ipr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [15:0] wr_data,
   input wire logic [1:0] wr_strb,
   output logic [15:0] value_q
);

   logic [15:0] lane_mask;
   logic [15:0] value_d;

   // byte lanes, then drop the unimplemented positions
   always_comb begin
      lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & PRIO_IMPL_MASK;
      value_d = (value_q & ~lane_mask) | (wr_data & lane_mask);
   end

   // storage, fields wake at level four
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         value_q <= PRIO_RESET;
      end else if (wr_en) begin
         value_q <= value_d & PRIO_IMPL_MASK;
      end
   end

endmodule

// *** design/ipr_src_enable.sv ***
/*
 * registered enable flag per interrupt source: a source whose
 * priority field is zero is held off.
 * assumes fields are packed three bits each, source zero lowest.
 */
`timescale 1ns/1ps

module ipr_src_enable
   import ipr_pkg::*;
#(
   parameter int N = NUM_SRCS
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [N*FIELD_W-1:0] levels,
   output logic [N-1:0] en_q
);

   genvar g;

   // one flag per source, cleared when its code is the off code
   generate
      for (g = 0; g < N; g++) begin : g_src
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               en_q[g] <= 1'b1;
            end else begin
               en_q[g] <= levels[g*FIELD_W +: FIELD_W] != PRIO_OFF;
            end
         end
      end
   endgenerate

endmodule

// *** design/ipr_regs_top.sv ***
/*
 * interrupt priority control registers six to ten behind an
 * axi4-lite slave, with every field driven out to the arbiter.
 * assumes one clock, an asynchronous active-low reset and a master
 * that keeps at most one write and one read under way.
 */
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
// Overview of operation
// - three-bit field, all ones is level seven
// - code one is lowest level, linear upward
// - code zero disables the source
// - bits 15, 11, 7, 3 read zero
// - fields reset to level four
// - six: timer4, oc4, oc3, dma2
// - seven: uart2 tx, uart2 rx, ext2, timer5
// - eight: can1 event, can1 rx, spi2, spi2 error
// - nine: ic5, ic4, ic3, dma3
// - ten: oc7, oc6, oc5, ic6
`timescale 1ns/1ps

module ipr_regs_top
   import ipr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // priority levels to the arbiter
   output logic [2:0] timer_four_prio,
   output logic [2:0] out_cmp_four_prio,
   output logic [2:0] out_cmp_three_prio,
   output logic [2:0] dma_chan_two_prio,
   output logic [2:0] uart_two_tx_prio,
   output logic [2:0] uart_two_rx_prio,
   output logic [2:0] ext_irq_two_prio,
   output logic [2:0] timer_five_prio,
   output logic [2:0] can_one_event_prio,
   output logic [2:0] can_one_rx_prio,
   output logic [2:0] spi_two_event_prio,
   output logic [2:0] spi_two_error_prio,
   output logic [2:0] in_cap_five_prio,
   output logic [2:0] in_cap_four_prio,
   output logic [2:0] in_cap_three_prio,
   output logic [2:0] dma_chan_three_prio,
   output logic [2:0] out_cmp_seven_prio,
   output logic [2:0] out_cmp_six_prio,
   output logic [2:0] out_cmp_five_prio,
   output logic [2:0] in_cap_six_prio,
   // per-source enable, low when the level is zero
   output logic [19:0] src_enable
);

   // write side state
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic aw_got_q;
   logic w_got_q;
   logic [7:0] awaddr_q;
   logic [15:0] wdata_q;
   logic [1:0] wstrb_q;

   // read side state
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // handshakes and decode
   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic do_write;
   logic wr_hit;
   logic [2:0] wr_idx;
   logic rd_hit;
   logic [2:0] rd_idx;
   logic [15:0] prio_q [0:4];
   logic [4:0] wr_sel;
   logic [59:0] all_levels;
   logic [19:0] src_en_q;

   // channel handshakes
   assign aw_fire = s_axi_awvalid & awready_q;
   assign w_fire = s_axi_wvalid & wready_q;
   assign ar_fire = s_axi_arvalid & arready_q;

   // a write goes ahead once address and data are both held
   assign do_write = aw_got_q & w_got_q & ~bvalid_q;

   // bus outputs straight from their flip-flops
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // write address ready: open while idle, shut from capture to response
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         awready_q <= 1'b0;
      end else if (aw_fire) begin
         awready_q <= 1'b0;
      end else if (!aw_got_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   // write data ready, same pattern as the address channel
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wready_q <= 1'b0;
      end else if (w_fire) begin
         wready_q <= 1'b0;
      end else if (!w_got_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   // hold the write address until the write is done
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_got_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (aw_fire) begin
         aw_got_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_got_q <= 1'b0;
      end
   end

   // hold the write data; only the low two lanes carry register bits
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         w_got_q <= 1'b0;
         wdata_q <= 16'h0000;
         wstrb_q <= 2'h0;
      end else if (w_fire) begin
         w_got_q <= 1'b1;
         wdata_q <= s_axi_wdata[15:0];
         wstrb_q <= s_axi_wstrb[1:0];
      end else if (do_write) begin
         w_got_q <= 1'b0;
      end
   end

   // write response, slverr for an address outside the bank
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // write address decode, low two address bits ignored
   always_comb begin
      wr_hit = 1'b1;
      wr_idx = IDX_SIX;
      case ({awaddr_q[7:2], 2'b00})
         OFF_PRIO_CTRL_SIX: wr_idx = IDX_SIX;
         OFF_PRIO_CTRL_SEVEN: wr_idx = IDX_SEVEN;
         OFF_PRIO_CTRL_EIGHT: wr_idx = IDX_EIGHT;
         OFF_PRIO_CTRL_NINE: wr_idx = IDX_NINE;
         OFF_PRIO_CTRL_TEN: wr_idx = IDX_TEN;
         default: wr_hit = 1'b0;
      endcase
   end

   // read address decode
   always_comb begin
      rd_hit = 1'b1;
      rd_idx = IDX_SIX;
      case ({s_axi_araddr[7:2], 2'b00})
         OFF_PRIO_CTRL_SIX: rd_idx = IDX_SIX;
         OFF_PRIO_CTRL_SEVEN: rd_idx = IDX_SEVEN;
         OFF_PRIO_CTRL_EIGHT: rd_idx = IDX_EIGHT;
         OFF_PRIO_CTRL_NINE: rd_idx = IDX_NINE;
         OFF_PRIO_CTRL_TEN: rd_idx = IDX_TEN;
         default: rd_hit = 1'b0;
      endcase
   end

   // read address ready: open while no read answer is pending
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         arready_q <= 1'b0;
      end else if (ar_fire) begin
         arready_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_q <= 1'b1;
         if (rd_hit) begin
            // upper half and unimplemented bits read as zero
            rdata_q <= {16'h0000, prio_q[rd_idx] & PRIO_IMPL_MASK};
            rresp_q <= RESP_OKAY;
         end else begin
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // one-hot write select per register
   always_comb begin
      wr_sel = 5'h00;
      if (do_write && wr_hit) begin
         wr_sel[wr_idx] = 1'b1;
      end
   end

   // the five priority control registers
   genvar r;
   generate
      for (r = 0; r < NUM_REGS; r++) begin : g_reg
         ipr_prio_reg u_reg (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .wr_en(wr_sel[r]),
            .wr_data(wdata_q),
            .wr_strb(wstrb_q),
            .value_q(prio_q[r])
         );
      end
   endgenerate

   // register six fields; codes pass as levels 0 to 7 unchanged
   assign timer_four_prio =
      prio_q[IDX_SIX][FLD_HI_LSB +: FIELD_W];
   assign out_cmp_four_prio =
      prio_q[IDX_SIX][FLD_MH_LSB +: FIELD_W];
   assign out_cmp_three_prio =
      prio_q[IDX_SIX][FLD_ML_LSB +: FIELD_W];
   assign dma_chan_two_prio =
      prio_q[IDX_SIX][FLD_LO_LSB +: FIELD_W];

   // register seven fields
   assign uart_two_tx_prio =
      prio_q[IDX_SEVEN][FLD_HI_LSB +: FIELD_W];
   assign uart_two_rx_prio =
      prio_q[IDX_SEVEN][FLD_MH_LSB +: FIELD_W];
   assign ext_irq_two_prio =
      prio_q[IDX_SEVEN][FLD_ML_LSB +: FIELD_W];
   assign timer_five_prio =
      prio_q[IDX_SEVEN][FLD_LO_LSB +: FIELD_W];

   // register eight fields
   assign can_one_event_prio =
      prio_q[IDX_EIGHT][FLD_HI_LSB +: FIELD_W];
   assign can_one_rx_prio =
      prio_q[IDX_EIGHT][FLD_MH_LSB +: FIELD_W];
   assign spi_two_event_prio =
      prio_q[IDX_EIGHT][FLD_ML_LSB +: FIELD_W];
   assign spi_two_error_prio =
      prio_q[IDX_EIGHT][FLD_LO_LSB +: FIELD_W];

   // register nine fields
   assign in_cap_five_prio =
      prio_q[IDX_NINE][FLD_HI_LSB +: FIELD_W];
   assign in_cap_four_prio =
      prio_q[IDX_NINE][FLD_MH_LSB +: FIELD_W];
   assign in_cap_three_prio =
      prio_q[IDX_NINE][FLD_ML_LSB +: FIELD_W];
   assign dma_chan_three_prio =
      prio_q[IDX_NINE][FLD_LO_LSB +: FIELD_W];

   // register ten fields
   assign out_cmp_seven_prio =
      prio_q[IDX_TEN][FLD_HI_LSB +: FIELD_W];
   assign out_cmp_six_prio =
      prio_q[IDX_TEN][FLD_MH_LSB +: FIELD_W];
   assign out_cmp_five_prio =
      prio_q[IDX_TEN][FLD_ML_LSB +: FIELD_W];
   assign in_cap_six_prio =
      prio_q[IDX_TEN][FLD_LO_LSB +: FIELD_W];

   // all twenty levels, 3'h7 highest down to 3'h1 lowest, 3'h0 off
   assign all_levels = {
      in_cap_six_prio, out_cmp_five_prio,
      out_cmp_six_prio, out_cmp_seven_prio,
      dma_chan_three_prio, in_cap_three_prio,
      in_cap_four_prio, in_cap_five_prio,
      spi_two_error_prio, spi_two_event_prio,
      can_one_rx_prio, can_one_event_prio,
      timer_five_prio, ext_irq_two_prio,
      uart_two_rx_prio, uart_two_tx_prio,
      dma_chan_two_prio, out_cmp_three_prio,
      out_cmp_four_prio, timer_four_prio
   };

   // a level of zero drops its source enable one clock edge later
   ipr_src_enable #(
      .N(NUM_SRCS)
   ) u_src_en (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .levels(all_levels),
      .en_q(src_en_q)
   );

   assign src_enable = src_en_q;

endmodule

// *** testbench/ipr_regs_checker.sv ***
/* checker for priority registers six to ten: read layout, reset
   levels, off code and level stability.
   assumes it is bound into ipr_regs_top and sees only its ports. */
`timescale 1ns/1ps
module ipr_regs_checker
   import ipr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_bvalid,
   input wire logic [2:0] timer_four_prio,
   input wire logic [2:0] out_cmp_four_prio,
   input wire logic [2:0] out_cmp_three_prio,
   input wire logic [2:0] dma_chan_two_prio,
   input wire logic [2:0] uart_two_tx_prio,
   input wire logic [2:0] uart_two_rx_prio,
   input wire logic [2:0] ext_irq_two_prio,
   input wire logic [2:0] timer_five_prio,
   input wire logic [2:0] can_one_event_prio,
   input wire logic [2:0] can_one_rx_prio,
   input wire logic [2:0] spi_two_event_prio,
   input wire logic [2:0] spi_two_error_prio,
   input wire logic [2:0] in_cap_five_prio,
   input wire logic [2:0] in_cap_four_prio,
   input wire logic [2:0] in_cap_three_prio,
   input wire logic [2:0] dma_chan_three_prio,
   input wire logic [2:0] out_cmp_seven_prio,
   input wire logic [2:0] out_cmp_six_prio,
   input wire logic [2:0] out_cmp_five_prio,
   input wire logic [2:0] in_cap_six_prio,
   input wire logic [19:0] src_enable
);
   logic [7:0] raddr_q;
   logic [59:0] lv;
   logic [15:0] rd16;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // all twenty levels, register six first
   assign lv = {timer_four_prio, out_cmp_four_prio, out_cmp_three_prio,
      dma_chan_two_prio, uart_two_tx_prio, uart_two_rx_prio,
      ext_irq_two_prio, timer_five_prio, can_one_event_prio,
      can_one_rx_prio, spi_two_event_prio, spi_two_error_prio,
      in_cap_five_prio, in_cap_four_prio, in_cap_three_prio,
      dma_chan_three_prio, out_cmp_seven_prio, out_cmp_six_prio,
      out_cmp_five_prio, in_cap_six_prio};
   assign rd16 = s_axi_rdata[15:0];

   // register image of four fields, gaps read as zero
   function automatic logic [15:0] pk(input logic [11:0] f);
      return {1'b0, f[11:9], 1'b0, f[8:6], 1'b0, f[5:3], 1'b0, f[2:0]};
   endfunction

   // address of the read under way
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         raddr_q <= 8'h00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         raddr_q <= s_axi_araddr;
      end
   end

   // a fresh read answer with an okay response
   sequence rd_ok;
      $rose(s_axi_rvalid) && s_axi_rresp == RESP_OKAY;
   endsequence

   six_map_a: assert property (rd_ok |->
      raddr_q != OFF_PRIO_CTRL_SIX || rd16 == pk($past(lv[59:48])))
      else $error("register six layout mismatch");
   seven_map_a: assert property (rd_ok |->
      raddr_q != OFF_PRIO_CTRL_SEVEN || rd16 == pk($past(lv[47:36])))
      else $error("register seven layout mismatch");
   eight_map_a: assert property (rd_ok |->
      raddr_q != OFF_PRIO_CTRL_EIGHT || rd16 == pk($past(lv[35:24])))
      else $error("register eight layout mismatch");
   nine_map_a: assert property (rd_ok |->
      raddr_q != OFF_PRIO_CTRL_NINE || rd16 == pk($past(lv[23:12])))
      else $error("register nine layout mismatch");
   ten_map_a: assert property (rd_ok |->
      raddr_q != OFF_PRIO_CTRL_TEN || rd16 == pk($past(lv[11:0])))
      else $error("register ten layout mismatch");
   unimpl_zero_a: assert property (s_axi_rvalid |->
      (s_axi_rdata & 32'hFFFF8888) == 32'h00000000)
      else $error("unimplemented read bits not zero");
   reset_level_a: assert property ($rose(arst_n) |->
      lv == {20{3'h4}}) else $error("levels not four after reset");
   src_off_a: assert property (timer_four_prio == PRIO_OFF |=>
      !src_enable[0]) else $error("disabled source still enabled");
   src_on_a: assert property (in_cap_six_prio != PRIO_OFF |=>
      src_enable[19]) else $error("active source not enabled");
   lv_hold_a: assert property (!$rose(s_axi_bvalid) |->
      $stable(lv)) else $error("levels changed without a write");
endmodule

bind ipr_regs_top ipr_regs_checker i_chk (.*);

// *** testbench/ipr_regs_top_tb.sv ***
/* self-checking bench for the priority registers six to ten.
   assumes the checker is bound in and a 25 MHz clock. */
`timescale 1ns/1ps
module ipr_regs_top_tb
   import ipr_pkg::*;
;
   typedef struct packed {logic [2:0] idx; logic [31:0] d; logic [3:0] s;
      logic [15:0] x;} ipr_row_t;
   logic sys_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] timer_four_prio, out_cmp_four_prio, out_cmp_three_prio;
   logic [2:0] dma_chan_two_prio, uart_two_tx_prio, uart_two_rx_prio;
   logic [2:0] ext_irq_two_prio, timer_five_prio, can_one_event_prio;
   logic [2:0] can_one_rx_prio, spi_two_event_prio, spi_two_error_prio;
   logic [2:0] in_cap_five_prio, in_cap_four_prio, in_cap_three_prio;
   logic [2:0] dma_chan_three_prio, out_cmp_seven_prio, out_cmp_six_prio;
   logic [2:0] out_cmp_five_prio, in_cap_six_prio;
   logic [19:0] src_enable;
   logic [59:0] lv;
   logic [15:0] mdl [5];
   logic [7:0] offs [5] = '{OFF_PRIO_CTRL_SIX, OFF_PRIO_CTRL_SEVEN,
      OFF_PRIO_CTRL_EIGHT, OFF_PRIO_CTRL_NINE, OFF_PRIO_CTRL_TEN};
   // register, write word, strobes, register value expected afterwards;
   // covers every code but 4, which only reset loads, and every lane mix
   ipr_row_t rows [7] = '{'{3'h0, 32'hFFFFFFFF, 4'hF, 16'h7777},
      '{3'h1, 32'h00003210, 4'hF, 16'h3210},
      '{3'h2, 32'h12345670, 4'h3, 16'h5670},
      '{3'h3, 32'h0000FFFF, 4'h1, 16'h4477},
      '{3'h4, 32'hFFFF0000, 4'h2, 16'h0044},
      '{3'h0, 32'h00000765, 4'hF, 16'h0765},
      '{3'h4, 32'hFFFFFFFF, 4'hC, 16'h0044}};
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic [1:0] rr;

   ipr_regs_top i_dut (.*);

   // levels as one vector, register six first
   assign lv = {timer_four_prio, out_cmp_four_prio, out_cmp_three_prio,
      dma_chan_two_prio, uart_two_tx_prio, uart_two_rx_prio,
      ext_irq_two_prio, timer_five_prio, can_one_event_prio,
      can_one_rx_prio, spi_two_event_prio, spi_two_error_prio,
      in_cap_five_prio, in_cap_four_prio, in_cap_three_prio,
      dma_chan_three_prio, out_cmp_seven_prio, out_cmp_six_prio,
      out_cmp_five_prio, in_cap_six_prio};

   // clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // one write; address and data released each as taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] r);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      check({62'h0, s_axi_bresp}, {62'h0, r});
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // reads every register and compares levels and enables to the model
   task automatic check_all();
      logic [59:0] e;
      logic [19:0] en;
      e = '0;
      for (int i = 0; i < 5; i++) begin
         axi_rd(offs[i], rd, rr);
         check({32'h0, rd}, {48'h0, mdl[i]});
         check({62'h0, rr}, {62'h0, RESP_OKAY});
         e = {e[47:0], mdl[i][14:12], mdl[i][10:8], mdl[i][6:4],
            mdl[i][2:0]};
      end
      for (int k = 0; k < 20; k++) en[k] = (e[59-3*k -: 3] != 3'h0);
      check({4'h0, lv}, {4'h0, e});
      check({4'h0, lv}, {4'h0, e});
      check({44'h0, src_enable}, {44'h0, en});
   endtask

   // outputs while reset is held low
   task automatic check_rst();
      logic [4:0] hs;
      hs = {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
         s_axi_rvalid};
      check({4'h0, lv}, {4'h0, {20{3'h4}}});
      check({59'h0, hs}, 64'h0);
      check({44'h0, src_enable}, {44'h0, 20'hFFFFF});
   endtask

   initial begin
      arst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
      s_axi_wdata = 32'h00000000;
      foreach (mdl[i]) mdl[i] = PRIO_RESET;
      repeat (2) @(posedge sys_clk);
      check_rst();
      arst_n <= 1'b1;
      check_all();
      foreach (rows[j]) begin
         axi_wr(offs[rows[j].idx], rows[j].d, rows[j].s, RESP_OKAY);
         mdl[rows[j].idx] = rows[j].x;
         check_all();
      end
      // unmapped place: refused, nothing stored
      axi_wr(8'h14, 32'h00007777, 4'hF, RESP_SLVERR);
      axi_rd(8'h14, rd, rr);
      check({62'h0, rr}, {62'h0, RESP_SLVERR});
      check({32'h0, rd}, 64'h0);
      check_all();
      // second reset in mid-run
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check_rst();
      arst_n <= 1'b1;
      foreach (mdl[i]) mdl[i] = PRIO_RESET;
      check_all();
      summarize();
   end
endmodule
